// ===== hdl/dsrsf_map.svh
// constants of the diskette result status flags block
`ifndef DSRSF_MAP_SVH
`define DSRSF_MAP_SVH

// result status byte 1 bit positions
`define DSRSF_B1_END_CYL    3'h7
`define DSRSF_B1_DATA_ERR   3'h5
`define DSRSF_B1_OVERRUN    3'h4
`define DSRSF_B1_NO_DATA    3'h2
`define DSRSF_B1_NOT_WR     3'h1
`define DSRSF_B1_MISS_AM    3'h0

// result status byte 2 bit positions
`define DSRSF_B2_CTRL_MARK  3'h6
`define DSRSF_B2_DATA_FLD   3'h5
`define DSRSF_B2_WRONG_CYL  3'h4
`define DSRSF_B2_SCAN_HIT   3'h3
`define DSRSF_B2_SCAN_NOT   3'h2
`define DSRSF_B2_BAD_CYL    3'h1
`define DSRSF_B2_MISS_DM    3'h0

// drive state status byte bit positions
`define DSRSF_B3_FAULT      3'h7
`define DSRSF_B3_WPROT      3'h6
`define DSRSF_B3_READY      3'h5
`define DSRSF_B3_TRACK0     3'h4
`define DSRSF_B3_TWO_SIDE   3'h3
`define DSRSF_B3_HEAD       3'h2

// byte reset value and the all-ones cylinder code
`define DSRSF_BYTE_RESET    8'h00
`define DSRSF_CYL_BAD       8'hff

// command select codes
`define DSRSF_CMD_RD_TRACK  5'h02
`define DSRSF_CMD_WRITE     5'h05
`define DSRSF_CMD_READ      5'h06
`define DSRSF_CMD_WR_DEL    5'h09
`define DSRSF_CMD_READ_ID   5'h0a
`define DSRSF_CMD_RD_DEL    5'h0c
`define DSRSF_CMD_FORMAT    5'h0d
`define DSRSF_CMD_SCAN_EQ   5'h11
`define DSRSF_CMD_SCAN_LE   5'h19
`define DSRSF_CMD_SCAN_HE   5'h1d

// status byte selection on the read port
`define DSRSF_SEL_RESULT1   2'h0
`define DSRSF_SEL_RESULT2   2'h1
`define DSRSF_SEL_DRIVE     2'h2

`endif

// ===== hdl/dsrsf_pkg.sv
// types of the diskette result status flags block
package dsrsf_pkg;

  typedef enum logic {
    DSRSF_IDLE,
    DSRSF_EXEC
  } dsrsf_phase_t;

  typedef logic [7:0] dsrsf_byte_t;

endpackage

// ===== hdl/dsrsf_drive_if.sv
// synchronised drive sense lines between the flag modules
`timescale 1ns/1ps
interface dsrsf_drive_if;
  logic fault;
  logic writeProtect;
  logic ready;
  logic track0;
  logic twoSide;

  modport src
  (
    output fault,
    output writeProtect,
    output ready,
    output track0,
    output twoSide
  );

  modport dst
  (
    input fault,
    input writeProtect,
    input ready,
    input track0,
    input twoSide
  );
endinterface

// ===== hdl/dsrsf_sync.sv
// two-stage synchroniser for the drive sense pins
`timescale 1ns/1ps
module dsrsf_sync
#(
  parameter int WIDTH = 5
)
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  dsrsf_drive_if.src            drv
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage1_reg[gi] <= 1'b0;
          stage2_reg[gi] <= 1'b0;
        end
        else
        begin
          stage1_reg[gi] <= pinIn[gi];
          stage2_reg[gi] <= stage1_reg[gi];
        end
      end
    end
  endgenerate

  assign drv.fault        = stage2_reg[0];
  assign drv.writeProtect = stage2_reg[1];
  assign drv.ready        = stage2_reg[2];
  assign drv.track0       = stage2_reg[3];
  assign drv.twoSide      = stage2_reg[4];

endmodule

// ===== hdl/dsrsf_top.sv
// result and drive state status bytes of the diskette controller
`timescale 1ns/1ps
`include "dsrsf_map.svh"
module dsrsf_top
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       drvFaultPin,
  input  wire logic       drvWriteProtectPin,
  input  wire logic       drvReadyPin,
  input  wire logic       drvTrack0Pin,
  input  wire logic       drvTwoSidePin,
  input  wire logic       cmdStart,
  input  wire logic       cmdDone,
  input  wire logic [4:0] cmdCode,
  input  wire logic       selHead,
  input  wire logic [1:0] selUnit,
  input  wire logic       nonDmaMode,
  input  wire logic       evSectorPastEnd,
  input  wire logic       evIdCrcError,
  input  wire logic       evDataCrcError,
  input  wire logic       evServiceMissed,
  input  wire logic       evSectorNotFound,
  input  wire logic       evIdNotRead,
  input  wire logic       evIndexTwiceNoId,
  input  wire logic       evDataMarkMissing,
  input  wire logic       evDeletedMark,
  input  wire logic       evIdValid,
  input  wire logic [7:0] idCylinder,
  input  wire logic [7:0] presentCylinder,
  input  wire logic       evScanEqual,
  input  wire logic       evScanNotMet,
  input  wire logic       statusRdEn,
  input  wire logic [1:0] statusRdSel,
  output logic      [7:0] statusRdData,
  output logic            cmdActive
);

  ////////////////////////////////////////////////////////////////////////////
  // command class decoding

  function automatic logic isScan(input logic [4:0] code);
    isScan = (code == `DSRSF_CMD_SCAN_EQ) || (code == `DSRSF_CMD_SCAN_LE) ||
             (code == `DSRSF_CMD_SCAN_HE);
  endfunction

  function automatic logic isRead(input logic [4:0] code);
    isRead = (code == `DSRSF_CMD_READ) || (code == `DSRSF_CMD_RD_DEL);
  endfunction

  function automatic logic isWriteClass(input logic [4:0] code);
    isWriteClass = (code == `DSRSF_CMD_WRITE) || (code == `DSRSF_CMD_WR_DEL) ||
                   (code == `DSRSF_CMD_FORMAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // drive pins, synchronised before use

  dsrsf_drive_if drv ();

  dsrsf_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pinIn   ({drvTwoSidePin, drvTrack0Pin, drvReadyPin, drvWriteProtectPin,
               drvFaultPin}),
    .drv     (drv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command phase

  dsrsf_pkg::dsrsf_phase_t phase_reg;
  dsrsf_pkg::dsrsf_phase_t phase_next;
  logic [4:0]              code_reg;

  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      dsrsf_pkg::DSRSF_IDLE:
        if (cmdStart)
          phase_next = dsrsf_pkg::DSRSF_EXEC;
      dsrsf_pkg::DSRSF_EXEC:
        if (cmdDone && !cmdStart)
          phase_next = dsrsf_pkg::DSRSF_IDLE;
      default:
        phase_next = dsrsf_pkg::DSRSF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_reg <= dsrsf_pkg::DSRSF_IDLE;
      code_reg  <= 5'h00;
    end
    else
    begin
      phase_reg <= phase_next;
      if (cmdStart)
        code_reg <= cmdCode;
    end
  end

  // events outside a command are dropped; they have no command to qualify them
  wire        inExec   = (phase_reg == dsrsf_pkg::DSRSF_EXEC);
  wire        cScan    = isScan(code_reg);
  wire        cRead    = isRead(code_reg);
  wire        cWrite   = isWriteClass(code_reg);
  wire        cRdTrack = (code_reg == `DSRSF_CMD_RD_TRACK);
  wire        cReadId  = (code_reg == `DSRSF_CMD_READ_ID);
  wire        cSector  = cRead || cScan || (code_reg == `DSRSF_CMD_WR_DEL);
  wire        cylDiff  = evIdValid && (idCylinder != presentCylinder);

  assign cmdActive = inExec;

  ////////////////////////////////////////////////////////////////////////////
  // set terms of result status byte 1

  wire setEndCyl  = inExec && evSectorPastEnd;
  wire setDataErr = inExec && (evIdCrcError || evDataCrcError);
  wire setOverrun = inExec && nonDmaMode && evServiceMissed;
  wire setNoData  = inExec && ((cSector && evSectorNotFound) ||
                               (cReadId && evIdNotRead) ||
                               (cRdTrack && evSectorNotFound));
  wire setNotWr   = inExec && cWrite && drv.writeProtect;
  // a missing data mark counts under any command, not only plain reads
  wire setMissAm  = inExec && (evIndexTwiceNoId ||
                               evDataMarkMissing);

  ////////////////////////////////////////////////////////////////////////////
  // set terms of result status byte 2

  wire setCtrlMark = inExec && (cRead || cScan) && evDeletedMark;
  wire setDataFld  = inExec && evDataCrcError;
  wire setWrongCyl = inExec && cylDiff;
  wire setBadCyl   = inExec && cylDiff && (idCylinder == `DSRSF_CYL_BAD);
  wire setScanHit  = inExec && cScan && evScanEqual;
  wire setScanNot  = inExec && cScan && evScanNotMet;
  wire setMissDm   = setMissAm;

  logic [7:0] set1;
  logic [7:0] set2;

  // unused positions have no set term and stay zero
  always_comb
  begin
    set1                     = `DSRSF_BYTE_RESET;
    set1[`DSRSF_B1_END_CYL]  = setEndCyl;
    set1[`DSRSF_B1_DATA_ERR] = setDataErr;
    set1[`DSRSF_B1_OVERRUN]  = setOverrun;
    set1[`DSRSF_B1_NO_DATA]  = setNoData;
    set1[`DSRSF_B1_NOT_WR]   = setNotWr;
    set1[`DSRSF_B1_MISS_AM]  = setMissAm;
    set2                      = `DSRSF_BYTE_RESET;
    set2[`DSRSF_B2_CTRL_MARK] = setCtrlMark;
    set2[`DSRSF_B2_DATA_FLD]  = setDataFld;
    set2[`DSRSF_B2_WRONG_CYL] = setWrongCyl;
    set2[`DSRSF_B2_SCAN_HIT]  = setScanHit;
    set2[`DSRSF_B2_SCAN_NOT]  = setScanNot;
    set2[`DSRSF_B2_BAD_CYL]   = setBadCyl;
    set2[`DSRSF_B2_MISS_DM]   = setMissDm;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, cleared by a new command; a set in the same cycle wins

  dsrsf_pkg::dsrsf_byte_t result1_reg;
  dsrsf_pkg::dsrsf_byte_t result2_reg;

  wire [7:0] result1Next = (cmdStart ? `DSRSF_BYTE_RESET : result1_reg) | set1;
  wire [7:0] result2Next = (cmdStart ? `DSRSF_BYTE_RESET : result2_reg) | set2;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result1_reg <= `DSRSF_BYTE_RESET;
      result2_reg <= `DSRSF_BYTE_RESET;
    end
    else
    begin
      result1_reg <= result1Next;
      result2_reg <= result2Next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive state byte, live from the synchronised pins and the unsynchronised head and unit selects

  logic [7:0] driveState;

  always_comb
  begin
    driveState                     = `DSRSF_BYTE_RESET;
    driveState[`DSRSF_B3_FAULT]    = drv.fault;
    driveState[`DSRSF_B3_WPROT]    = drv.writeProtect;
    driveState[`DSRSF_B3_READY]    = drv.ready;
    driveState[`DSRSF_B3_TRACK0]   = drv.track0;
    driveState[`DSRSF_B3_TWO_SIDE] = drv.twoSide;
    driveState[`DSRSF_B3_HEAD]     = selHead;
    driveState[1:0]                = selUnit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; the byte is captured so it holds steady for the host

  wire [7:0] rdMux = (statusRdSel == `DSRSF_SEL_RESULT1) ? result1_reg :
                     (statusRdSel == `DSRSF_SEL_RESULT2) ? result2_reg :
                     (statusRdSel == `DSRSF_SEL_DRIVE)   ? driveState  :
                     `DSRSF_BYTE_RESET;

  logic [7:0] rdData_reg;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdData_reg <= `DSRSF_BYTE_RESET;
    else if (statusRdEn)
      rdData_reg <= rdMux;
  end

  assign statusRdData = rdData_reg;

endmodule

// ===== tb/dsrsf_drive_model.sv
// behavioural diskette drive driving its sense pins
`timescale 1ns/1ps
module dsrsf_drive_model
(
  input  logic       clk_sys,
  input  logic [4:0] want,
  output logic [4:0] pins
);
  // levels only; contact bounce is not modelled
  initial pins = 5'h00;
  always @(posedge clk_sys)
    pins <= want;
endmodule

// ===== tb/dsrsf_top_asserts.sv
// concurrent checks on the status byte ports
`timescale 1ns/1ps
module dsrsf_top_asserts
(
  input logic       clk_sys,
  input logic       arst_n,
  input logic       drvFaultPin,
  input logic       drvWriteProtectPin,
  input logic       drvReadyPin,
  input logic       drvTrack0Pin,
  input logic       drvTwoSidePin,
  input logic       cmdStart,
  input logic       cmdDone,
  input logic       selHead,
  input logic [1:0] selUnit,
  input logic       statusRdEn,
  input logic [1:0] statusRdSel,
  input logic [7:0] statusRdData,
  input logic       cmdActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // pins held long enough to pass the two-stage synchroniser
  sequence pinsSettled;
    $stable({drvFaultPin, drvWriteProtectPin, drvReadyPin, drvTrack0Pin, drvTwoSidePin})[*3];
  endsequence
  sequence driveRead;
    statusRdEn && statusRdSel == 2'h2;
  endsequence
  sequence startRead;
    cmdStart && !cmdActive ##1 statusRdEn && statusRdSel != 2'h2;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_drive_pins: assert property (pinsSettled ##0 driveRead |=>
    statusRdData[7:3] == $past({drvFaultPin, drvWriteProtectPin, drvReadyPin,
    drvTrack0Pin, drvTwoSidePin})) else $error("drive pins not in drive byte");
  a_drive_unit: assert property (driveRead |=>
    statusRdData[2:0] == {$past(selHead), $past(selUnit)}) else $error("unit or side wrong");
  a_unused_b1: assert property (statusRdEn && statusRdSel == 2'h0 |=>
    !statusRdData[6] && !statusRdData[3]) else $error("unused byte1 bit set");
  a_unused_b2: assert property (statusRdEn && statusRdSel == 2'h1 |=>
    !statusRdData[7]) else $error("unused byte2 bit set");
  a_fresh_zero: assert property (startRead |=> statusRdData == 8'h00)
    else $error("flags not cleared by start");
  a_flags_sticky: assert property (statusRdEn && statusRdSel == 2'h1 && !cmdStart ##1
    statusRdEn && statusRdSel == 2'h1 |=>
    (statusRdData & $past(statusRdData)) == $past(statusRdData)) else $error("flag lost");
  a_sel_spare: assert property (statusRdEn && statusRdSel == 2'h3 |=>
    statusRdData == 8'h00) else $error("spare select not zero");
  a_cmd_rise: assert property (cmdStart |=> cmdActive)
    else $error("start did not open phase");
  a_cmd_fall: assert property (cmdDone && !cmdStart |=> !cmdActive)
    else $error("done did not close phase");
endmodule
bind dsrsf_top dsrsf_top_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .drvFaultPin(drvFaultPin), .drvWriteProtectPin(drvWriteProtectPin),
  .drvReadyPin(drvReadyPin), .drvTrack0Pin(drvTrack0Pin), .drvTwoSidePin(drvTwoSidePin),
  .cmdStart(cmdStart), .cmdDone(cmdDone), .selHead(selHead), .selUnit(selUnit),
  .statusRdEn(statusRdEn), .statusRdSel(statusRdSel), .statusRdData(statusRdData),
  .cmdActive(cmdActive));

// ===== tb/dsrsf_top_tb.sv
// self-checking bench for the status flag bytes
`timescale 1ns/1ps
module dsrsf_top_tb;
  localparam int LIMIT = 40000;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [4:0]  want = 5'h00;
  logic [4:0]  pins;
  logic        cmdStart = 1'b0;
  logic        cmdDone = 1'b0;
  logic [4:0]  cmdCode = 5'h00;
  logic        selHead = 1'b0;
  logic [1:0]  selUnit = 2'h0;
  logic        nonDma = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [7:0]  idCyl = 8'h00;
  logic [7:0]  presCyl = 8'h00;
  logic        rdEn = 1'b0;
  logic [1:0]  rdSel = 2'h0;
  logic [7:0]  rdData;
  logic        cmdActive;
  int          fail_count = 0;
  int          compares = 0;
  int          e1;
  int          e2;
  logic [4:0]  codes [10] = '{5'h02, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h11,
                              5'h19, 5'h1d};
  always #5 clk_sys = ~clk_sys;
  dsrsf_drive_model drive (.clk_sys(clk_sys), .want(want), .pins(pins));
  dsrsf_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .drvFaultPin(pins[4]),
    .drvWriteProtectPin(pins[3]), .drvReadyPin(pins[2]), .drvTrack0Pin(pins[1]),
    .drvTwoSidePin(pins[0]), .cmdStart(cmdStart), .cmdDone(cmdDone), .cmdCode(cmdCode),
    .selHead(selHead), .selUnit(selUnit), .nonDmaMode(nonDma), .evSectorPastEnd(ev[0]),
    .evIdCrcError(ev[1]), .evDataCrcError(ev[2]), .evServiceMissed(ev[3]),
    .evSectorNotFound(ev[4]), .evIdNotRead(ev[5]), .evIndexTwiceNoId(ev[6]),
    .evDataMarkMissing(ev[7]), .evDeletedMark(ev[8]), .evIdValid(ev[9]),
    .idCylinder(idCyl), .presentCylinder(presCyl), .evScanEqual(ev[10]),
    .evScanNotMet(ev[11]), .statusRdEn(rdEn), .statusRdSel(rdSel), .statusRdData(rdData),
    .cmdActive(cmdActive));
  ////////////////////////////////////////////////////////////////////////////
  // expected result bytes for one event under one command
  function automatic void model(input logic [4:0] c, input int i);
    bit rd = (c == 5'h06 || c == 5'h0c);
    bit sc = (c == 5'h11 || c == 5'h19 || c == 5'h1d);
    bit mk = (i == 6) || (i == 7);
    e1 = int'(i == 0) << 7 | int'(i == 1 || i == 2) << 5 | int'(i == 3 && nonDma) << 4
       | int'((i == 4 && (rd || sc || c == 5'h09 || c == 5'h02)) || (i == 5 && c == 5'h0a)) << 2
       | int'((c == 5'h05 || c == 5'h09 || c == 5'h0d) && want[3]) << 1 | int'(mk);
    e2 = int'(i == 8 && (rd || sc)) << 6 | int'(i == 2) << 5
       | int'(i == 9 && idCyl != presCyl) << 4 | int'(i == 10 && sc) << 3
       | int'(i == 11 && sc) << 2 | int'(i == 9 && idCyl == 8'hff && presCyl != 8'hff) << 1
       | int'(mk);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] exp);
    rdSel = s;
    rdEn = 1'b1;
    @(negedge clk_sys);
    chk(rdData, exp);
  endtask
  task automatic runOne(input logic [4:0] c, input int i);
    want = 5'($urandom);
    {selHead, selUnit, nonDma} = 4'($urandom);
    idCyl = ($urandom % 3 == 0) ? 8'hff : 8'($urandom % 4);
    presCyl = 8'($urandom % 4);
    repeat (4) @(negedge clk_sys);
    model(c, i);
    cmdCode = c;
    cmdStart = 1'b1;
    @(negedge clk_sys);
    cmdStart = 1'b0;
    ev[i] = 1'b1;
    rdEn = 1'b1;
    rdSel = 2'h0;
    @(negedge clk_sys);
    ev = 12'h000;
    chk(rdData, 8'h00);
    chk(8'(cmdActive), 8'h01);
    rd(2'h0, 8'(e1));
    rd(2'h1, 8'(e2));
    rd(2'h1, 8'(e2));
    rd(2'h2, {want, selHead, selUnit});
    rd(2'h3, 8'h00);
    rdEn = 1'b0;
    cmdDone = 1'b1;
    @(negedge clk_sys);
    cmdDone = 1'b0;
    chk(8'(cmdActive), 8'h00);
  endtask
  task automatic conclude();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h1ed1ae1f));
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    foreach (codes[k])
      for (int i = 0; i < 12; i++)
        runOne(codes[k], i);
    conclude();
  end
  // bound well above 120 commands of 12 cycles each
  initial
  begin
    #(LIMIT);
    fail_count++;
    conclude();
  end
endmodule
